// *** verilog/cfg_set_pkg.sv ***
/*
  constants, field layouts and enumerations shared by the configuration set manager.
  assumes a single 10 MHz clock and a synchronous active-high reset.
*/
package cfg_set_pkg;

  // ----------------------------------------------------------------
  // parameter set layout
  // ----------------------------------------------------------------
  localparam int unsigned SET_W       = 32;
  localparam int unsigned GAIN_LSB    = 0;
  localparam int unsigned GAIN_W      = 12;
  localparam int unsigned EXPO_LSB    = 12;
  localparam int unsigned EXPO_W      = 16;
  localparam int unsigned GAIN_AUTO_B = 28;
  localparam int unsigned EXPO_AUTO_B = 29;
  localparam int unsigned GAIN_MIN_B  = 30;
  localparam int unsigned SLOT_CNT    = 3;
  localparam int unsigned LUT_W       = 8;

  // ----------------------------------------------------------------
  // factory values
  // ----------------------------------------------------------------
  localparam logic [GAIN_W-1:0] GAIN_LOW     = 12'h040;
  localparam logic [GAIN_W-1:0] GAIN_6DB_ADD = 12'h040;
  localparam logic [EXPO_W-1:0] EXPO_STD     = 16'h2710;

  // ----------------------------------------------------------------
  // selector encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FAC_STANDARD = 2'h0,
    FAC_HIGHGAIN = 2'h1,
    FAC_AUTOFUNC = 2'h2
  } factory_t;

  typedef enum logic [1:0] {
    SEL_DEFAULT = 2'h0,
    SEL_USER1   = 2'h1,
    SEL_USER2   = 2'h2,
    SEL_USER3   = 2'h3
  } set_sel_t;

  localparam factory_t FAC_RESET     = FAC_STANDARD;
  localparam set_sel_t STARTUP_RESET = SEL_DEFAULT;

  // ----------------------------------------------------------------
  // result codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RES_NONE   = 2'h0,
    RES_OK     = 2'h1,
    RES_BUSY   = 2'h2,
    RES_BADSEL = 2'h3
  } result_t;

endpackage : cfg_set_pkg

// *** verilog/factory_rom.sv ***
/*
  the three fixed factory setups as constant logic, never writable.
  assumes the selector is stable in the same cycle it is read.
*/
`timescale 1ns/1ps

module factory_rom
  import cfg_set_pkg::*;
(
  input  wire factory_t         which,
  output logic     [SET_W-1:0]  setOut
);

  // ----------------------------------------------------------------
  // setup contents
  // ----------------------------------------------------------------
  logic [GAIN_W-1:0] gainHigh;

  assign gainHigh = GAIN_LOW + GAIN_6DB_ADD;

  always_comb begin
    setOut = '0;
    setOut[EXPO_LSB +: EXPO_W] = EXPO_STD;
    setOut[GAIN_LSB +: GAIN_W] = GAIN_LOW;
    unique case (which)
      FAC_HIGHGAIN: begin
        setOut[GAIN_LSB +: GAIN_W] = gainHigh;
      end
      FAC_AUTOFUNC: begin
        setOut[GAIN_AUTO_B] = 1'b1;
        setOut[EXPO_AUTO_B] = 1'b1;
        setOut[GAIN_MIN_B]  = 1'b1;
      end
      default: begin
        setOut[GAIN_LSB +: GAIN_W] = GAIN_LOW;
      end
    endcase
  end

endmodule : factory_rom

// *** verilog/cfg_set_manager.sv ***
/*
  configuration set manager: live set, default choice, three user slots, startup load.
  assumes command strobes are one-cycle pulses from logic on clk, and that the
  acquisition busy flag comes from the same clock domain.
*/
`timescale 1ns/1ps

module cfg_set_manager
  import cfg_set_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              acqBusy,
  input  wire logic [1:0]        setSelect,
  input  wire logic              saveCmd,
  input  wire logic              loadCmd,
  input  wire logic [1:0]        defaultSelect,
  input  wire logic              defaultWrite,
  input  wire logic [1:0]        startupSelect,
  input  wire logic              startupWrite,
  input  wire logic              liveWrite,
  input  wire logic [SET_W-1:0]  liveWriteData,
  input  wire logic              lutWrite,
  input  wire logic [LUT_W-1:0]  lutWriteData,
  output logic      [SET_W-1:0]  liveSet,
  output logic      [LUT_W-1:0]  lutValue,
  output logic      [1:0]        defaultChoice,
  output logic      [1:0]        startupChoice,
  output logic                   ready,
  output logic                   cmdDone,
  output logic      [1:0]        cmdResult
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_BOOT = 2'b01,
    ST_RUN  = 2'b10
  } phase_t;

  // volatile part, cleared by reset
  typedef struct packed {
    phase_t              phase;
    logic [SET_W-1:0]    live;
    logic [LUT_W-1:0]    lut;
    logic                done;
    result_t             result;
  } vol_t;

  // non-volatile part: models storage that keeps its content through reset
  typedef struct packed {
    logic                primed;
    factory_t            fac;
    set_sel_t            startup;
    logic [SLOT_CNT-1:0][SET_W-1:0] slot;
  } nv_t;

  vol_t vol_q;
  vol_t vol_d;
  // power-on content of fresh storage: nothing primed, shipping selections in place,
  // so the startup fetch never reads an undefined selection
  nv_t  nv_q = '{primed: 1'b0, fac: FAC_RESET, startup: STARTUP_RESET, slot: '0};
  nv_t  nv_d;

  logic [SET_W-1:0] facSet;
  logic [SET_W-1:0] startSet;
  logic [SET_W-1:0] loadSet;
  factory_t         facEff;

  // ----------------------------------------------------------------
  // stored set fetch
  // ----------------------------------------------------------------
  // first boot before storage is primed falls back to shipping values
  assign facEff = nv_q.primed ? nv_q.fac : FAC_RESET;

  factory_rom romInst (
    .which  (facEff),
    .setOut (facSet)
  );

  function automatic logic [SET_W-1:0] pickSet(
    input logic [1:0]                    sel,
    input logic [SET_W-1:0]              dflt,
    input logic [SLOT_CNT-1:0][SET_W-1:0] slots
  );
    logic [SET_W-1:0] r;
    r = dflt;
    if (sel != SEL_DEFAULT) begin
      r = slots[sel - 2'h1];
    end
    return r;
  endfunction : pickSet

  assign startSet = nv_q.primed ? pickSet(nv_q.startup, facSet, nv_q.slot) : facSet;
  assign loadSet  = pickSet(setSelect, facSet, nv_q.slot);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    vol_d      = vol_q;
    nv_d       = nv_q;
    vol_d.done = 1'b0;
    unique case (vol_q.phase)
      ST_BOOT: begin
        vol_d.live  = startSet;
        vol_d.phase = ST_RUN;
      end
      ST_RUN: begin
        if (liveWrite) begin
          vol_d.live = liveWriteData;
        end
        if (lutWrite) begin
          vol_d.lut = lutWriteData;
        end
        if (saveCmd) begin
          vol_d.done = 1'b1;
          if (setSelect == SEL_DEFAULT) begin
            vol_d.result = RES_BADSEL;
          end else begin
            // lut is deliberately outside the saved word
            nv_d.slot[setSelect - 2'h1] = vol_q.live;
            vol_d.result = RES_OK;
          end
        end else if (loadCmd) begin
          vol_d.done = 1'b1;
          if (acqBusy) begin
            vol_d.result = RES_BUSY;
          end else begin
            vol_d.live   = loadSet;
            vol_d.result = RES_OK;
          end
        end else if (defaultWrite) begin
          vol_d.done = 1'b1;
          if (acqBusy) begin
            vol_d.result = RES_BUSY;
          end else if (defaultSelect > FAC_AUTOFUNC) begin
            vol_d.result = RES_BADSEL;
          end else begin
            nv_d.fac     = factory_t'(defaultSelect);
            vol_d.result = RES_OK;
          end
        end
        if (startupWrite) begin
          nv_d.startup = set_sel_t'(startupSelect);
        end
        if (saveCmd || defaultWrite || startupWrite) begin
          if (!nv_q.primed) begin
            // first write of storage: fill untouched fields with shipping values
            nv_d.primed = 1'b1;
            if (!(defaultWrite && !acqBusy && !saveCmd && !loadCmd)) begin
              nv_d.fac = FAC_RESET;
            end
            if (!startupWrite) begin
              nv_d.startup = STARTUP_RESET;
            end
          end
        end
      end
      default: begin
        vol_d.phase = ST_BOOT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // volatile state clears on reset; the storage image has no reset
  // term, so a reset alone never erases slots or selections
  always_ff @(posedge clk) begin
    if (rst) begin
      vol_q.phase  <= ST_BOOT;
      vol_q.live   <= '0;
      vol_q.lut    <= '0;
      vol_q.done   <= 1'b0;
      vol_q.result <= RES_NONE;
    end else begin
      vol_q <= vol_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst) begin
      nv_q <= nv_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign liveSet       = vol_q.live;
  assign lutValue      = vol_q.lut;
  // run phase is its own one-hot bit, so ready needs no decode
  assign ready         = vol_q.phase[1];
  assign cmdDone       = vol_q.done;
  assign cmdResult     = vol_q.result;
  // storage powers up holding the shipping values, so no mux is needed here
  assign defaultChoice = nv_q.fac;
  assign startupChoice = nv_q.startup;

endmodule : cfg_set_manager

// *** test/cfg_set_checker.sv ***
/*
  concurrent checks on the configuration set manager ports.
  assumes binding to cfg_set_manager with clk and synchronous rst.
*/
`timescale 1ns/1ps
module cfg_set_checker
  import cfg_set_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             acqBusy,
  input wire logic [1:0]       setSelect,
  input wire logic             saveCmd,
  input wire logic             loadCmd,
  input wire logic [1:0]       defaultSelect,
  input wire logic             defaultWrite,
  input wire logic             liveWrite,
  input wire logic [SET_W-1:0] liveSet,
  input wire logic [LUT_W-1:0] lutValue,
  input wire logic [1:0]       defaultChoice,
  input wire logic             ready,
  input wire logic             cmdDone,
  input wire logic [1:0]       cmdResult
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic ld;
  logic dw;
  assign ld = ready && loadCmd && !saveCmd;
  assign dw = ready && defaultWrite && !saveCmd && !loadCmd;
  sequence s_res(logic [1:0] r);
    cmdDone && cmdResult == r;
  endsequence
  property p_busy_load;
    ld && acqBusy && !liveWrite |=> s_res(2'h2) ##0 $stable(liveSet);
  endproperty
  a_busy_load: assert property (p_busy_load) else $error("busy load changed state");
  property p_idle_load;
    ld && !acqBusy |=> s_res(2'h1);
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle load not ok");
  property p_busy_dflt;
    dw && acqBusy |=> s_res(2'h2) ##0 $stable(defaultChoice);
  endproperty
  a_busy_dflt: assert property (p_busy_dflt) else $error("busy default change");
  property p_dflt_set;
    dw && !acqBusy && defaultSelect != 2'h3 |=> s_res(2'h1) ##0
      defaultChoice == $past(defaultSelect);
  endproperty
  a_dflt_set: assert property (p_dflt_set) else $error("default not taken");
  property p_bad_save;
    ready && saveCmd && setSelect == 2'h0 |=> s_res(2'h3);
  endproperty
  a_bad_save: assert property (p_bad_save) else $error("save to default ok");
  property p_done_cause;
    cmdDone |-> $past(ready && (saveCmd || loadCmd || defaultWrite));
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("stray done");
  property p_start;
    $fell(rst) |-> ##[1:2] ready;
  endproperty
  a_start: assert property (p_start) else $error("no startup load");
  property p_hold;
    ready && !loadCmd && !liveWrite |=> $stable(liveSet);
  endproperty
  a_hold: assert property (p_hold) else $error("live set moved");
  property p_rst;
    disable iff (1'b0) rst ##1 rst |-> liveSet == '0 && lutValue == '0 && !ready;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not clearing");
endmodule : cfg_set_checker

bind cfg_set_manager cfg_set_checker chk_u (.clk(clk), .rst(rst), .acqBusy(acqBusy),
  .setSelect(setSelect), .saveCmd(saveCmd), .loadCmd(loadCmd),
  .defaultSelect(defaultSelect), .defaultWrite(defaultWrite), .liveWrite(liveWrite),
  .liveSet(liveSet), .lutValue(lutValue), .defaultChoice(defaultChoice), .ready(ready),
  .cmdDone(cmdDone), .cmdResult(cmdResult));

// *** test/cfg_set_manager_tb.sv ***
/*
  self-checking bench for cfg_set_manager.
  assumes one 10 MHz clock and commands taken once ready is high.
*/
`timescale 1ns/1ps
module cfg_set_manager_tb;
  import cfg_set_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic             clk = 0, rst = 1, acqBusy = 0, saveCmd = 0, loadCmd = 0;
  logic             defaultWrite = 0, startupWrite = 0, liveWrite = 0, lutWrite = 0;
  logic [1:0]       setSelect = 0, defaultSelect = 0, startupSelect = 0;
  logic [SET_W-1:0] liveWriteData = 0;
  logic [LUT_W-1:0] lutWriteData = 0;
  logic [SET_W-1:0] liveSet;
  logic [LUT_W-1:0] lutValue;
  logic [1:0]       defaultChoice, startupChoice, cmdResult;
  logic             ready, cmdDone;
  int               n_fail = 0, num_checks = 0, cyc = 0;
  logic [SET_W-1:0] fac [3];
  cfg_set_manager dut_u (.clk(clk), .rst(rst), .acqBusy(acqBusy), .setSelect(setSelect),
    .saveCmd(saveCmd), .loadCmd(loadCmd), .defaultSelect(defaultSelect),
    .defaultWrite(defaultWrite), .startupSelect(startupSelect), .startupWrite(startupWrite),
    .liveWrite(liveWrite), .liveWriteData(liveWriteData), .lutWrite(lutWrite),
    .lutWriteData(lutWriteData), .liveSet(liveSet), .lutValue(lutValue),
    .defaultChoice(defaultChoice), .startupChoice(startupChoice), .ready(ready),
    .cmdDone(cmdDone), .cmdResult(cmdResult));
  initial forever #50 clk = ~clk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cmd(input int k, input logic [1:0] s, input logic [1:0] r);
    @(posedge clk);
    setSelect     <= s;
    defaultSelect <= s;
    saveCmd       <= (k == 0);
    loadCmd       <= (k == 1);
    defaultWrite  <= (k == 2);
    @(posedge clk);
    saveCmd      <= 0;
    loadCmd      <= 0;
    defaultWrite <= 0;
    #1;
    chk(32'(cmdDone), 1);
    chk(32'(cmdResult), 32'(r));
  endtask : cmd
  // k: 0 live write, 1 lookup write, 2 startup choice
  task automatic wr(input int k, input logic [31:0] d);
    @(posedge clk);
    liveWriteData <= d;
    lutWriteData  <= d[7:0];
    startupSelect <= d[1:0];
    liveWrite     <= (k == 0);
    lutWrite      <= (k == 1);
    startupWrite  <= (k == 2);
    @(posedge clk);
    liveWrite    <= 0;
    lutWrite     <= 0;
    startupWrite <= 0;
    #1;
  endtask : wr
  task automatic rstSeq(input int n);
    @(posedge clk);
    rst <= 1;
    repeat (n) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask : rstSeq
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // ------------------------------------------------------------
  // watchdog: whole run is well under 400 cycles
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      $display("MISMATCH t=%0t watchdog expired", $time);
      n_fail++;
      results();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    fac[0] = {4'h0, EXPO_STD, GAIN_LOW};
    fac[1] = {4'h0, EXPO_STD, GAIN_LOW + GAIN_6DB_ADD};
    fac[2] = {4'h7, EXPO_STD, GAIN_LOW};
    rstSeq(20);
    chk(liveSet, fac[0]);
    chk(32'(ready), 1);
    $display("test startup done");
    for (int f = 0; f < 3; f++) begin
      cmd(2, f[1:0], 2'h1);
      cmd(1, SEL_DEFAULT, 2'h1);
      chk(liveSet, fac[f]);
    end
    cmd(2, 2'h3, 2'h3);
    @(posedge clk) acqBusy <= 1;
    cmd(2, 2'h0, 2'h2);
    cmd(1, SEL_USER1, 2'h2);
    chk(32'(defaultChoice), 2);
    chk(liveSet, fac[2]);
    @(posedge clk) acqBusy <= 0;
    $display("test factory done");
    for (int s = 1; s < 4; s++) begin
      wr(0, 32'h1111_1111 * s);
      cmd(0, s[1:0], 2'h1);
    end
    cmd(0, SEL_DEFAULT, 2'h3);
    for (int s = 3; s > 0; s--) begin
      cmd(1, s[1:0], 2'h1);
      chk(liveSet, 32'h1111_1111 * s);
    end
    wr(0, 32'hCAFE_0002);
    cmd(0, SEL_USER2, 2'h1);
    wr(0, 32'h0);
    cmd(1, SEL_USER2, 2'h1);
    chk(liveSet, 32'hCAFE_0002);
    $display("test user sets done");
    wr(1, 32'hA5);
    chk(32'(lutValue), 32'hA5);
    wr(2, 32'(SEL_USER2));
    rstSeq(3);
    chk(32'(lutValue), 0);
    chk(liveSet, 32'hCAFE_0002);
    chk(32'(defaultChoice), 2);
    chk(32'(startupChoice), 2);
    wr(2, 32'(SEL_DEFAULT));
    rstSeq(3);
    chk(liveSet, fac[2]);
    $display("test restart done");
    results();
  end
endmodule : cfg_set_manager_tb
